// file: common/rtfl_pkg.sv
// Constants shared by the ramp, readback and fast-lock control block.
// Assumes a 32-bit APB slave with every register on an aligned word.
package rtfl_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_R0     = 8'h00;
    localparam logic [7:0] ADDR_R1     = 8'h04;
    localparam logic [7:0] ADDR_R2     = 8'h08;
    localparam logic [7:0] ADDR_R3     = 8'h0C;
    localparam logic [7:0] ADDR_R4     = 8'h10;
    localparam logic [7:0] ADDR_R5     = 8'h14;
    localparam logic [7:0] ADDR_R6     = 8'h18;
    localparam logic [7:0] ADDR_STAT   = 8'h1C;
    localparam logic [7:0] ADDR_HINT   = 8'h20;
    localparam logic [7:0] ADDR_HFRAC  = 8'h24;
    // Reset value of every control register.
    localparam logic [31:0] REG_RESET  = 32'h0000_0000;
    // Field positions.
    localparam int R0_START   = 31;
    localparam int MUX_HI     = 30, MUX_LO   = 27;
    localparam int INT_HI     = 26, INT_LO   = 15;
    localparam int FRM_HI     = 14, FRM_LO   = 3;
    localparam int FRL_HI     = 27, FRL_LO   = 15;
    localparam int RDIV_HI    = 14, RDIV_LO  = 3;
    localparam int RMODE_HI   = 11, RMODE_LO = 10;
    localparam int TEST_HI    = 25, TEST_LO  = 21;
    localparam int RB_HI      = 22, RB_LO    = 21;
    localparam int FL_HI      = 20, FL_LO    = 19;
    localparam int SDIV_HI    = 18, SDIV_LO  = 7;
    localparam int EXT_STEP   = 29;
    localparam int IRQ_HI     = 27, IRQ_LO   = 26;
    localparam int DEV_HI     = 18, DEV_LO   = 3;
    localparam int STEPS_HI   = 22, STEPS_LO = 3;
    // Field codes.
    localparam logic [3:0] MUX_SEL_RAMP   = 4'hF;
    localparam logic [4:0] TEST_RAMP_DONE = 5'h03;
    localparam logic [1:0] RB_ENABLE      = 2'h2;
    localparam logic [1:0] IRQ_OFF        = 2'h0;
    localparam logic [1:0] IRQ_CONTINUE   = 2'h1;
    localparam logic [1:0] IRQ_STOP       = 2'h3;
    localparam logic [1:0] FL_OFF         = 2'h0;
    localparam logic [1:0] FL_DIVIDER     = 2'h1;
    localparam logic [1:0] RMODE_BURST    = 2'h3;
    // Widths of the divide words and the readback word.
    localparam int INT_W   = 12;
    localparam int FRAC_W  = 25;
    localparam int RB_W    = INT_W + FRAC_W;
endpackage

// file: rtl/rtfl_core.sv
// Ramp stepping, interrupt readback, fast-lock timer and third-order
// sigma-delta modulator of a fractional-N synthesizer.
// Assumes i_clock is the phase-detector clock and an APB master
// on the same clock; trigger and serial clock pins are asynchronous.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// Notes on behaviour
// - Mux select 1111 and test field 00011 put ramp-complete on output pin.
// - External-step bit bypasses ramp timer; trigger pulses advance each step.
// - Interrupts are detected on the rising edge of the trigger pin.
// - Interrupt mode 00 off, 01 interrupt and continue, 11 interrupt and halt.
// - After interrupt a 37-bit word, 12 integer then 25 fraction, reads out.
// - With fast lock enabled each R0 write starts a wide-bandwidth interval; here an R0 write that sets the ramp start bit starts none.
// - Interval length is ramp divider times second divider clock periods.
// - Fast-lock timer stays inactive while a ramp is running.
// - Fast-lock mode 01 boosts pump x16 and closes both filter switches.
// - Modulator is third order, 25-bit modulus, updated every clock.
module rtfl_core
    import rtfl_pkg::*;
(
    input  wire logic        i_clock,                  // Phase-detector clock.
    input  wire logic        i_rstn,                   // Async reset, active low.
    input  wire logic        psel,                     // APB select.
    input  wire logic        penable,                  // APB access phase.
    input  wire logic        pwrite,                   // APB write.
    input  wire logic [7:0]  paddr,                    // APB byte address.
    input  wire logic [31:0] pwdata,                   // APB write data.
    output logic      [31:0] prdata,                   // APB read data.
    output logic             pready,                   // APB ready.
    output logic             pslverr,                  // APB error.
    input  wire logic        i_step_trigger_pin,       // Step and interrupt pin.
    input  wire logic        i_readback_clock_pin,     // Shifts readback bits.
    output logic             o_multiplexed_output_pin, // Muxed output pin.
    output logic             o_pump_gain_x16,          // Charge pump boost.
    output logic             o_filter_switch_ground,   // Switch to ground.
    output logic             o_filter_switch_pump,     // Switch to pump out.
    output logic [11:0]      o_divide_int,             // Integer divide value.
    output logic [3:0]       o_divide_offset           // Signed modulator offset.
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic              trig_s1, trig_s2, trig_d;
        logic              sclk_s1, sclk_s2, sclk_d;
        logic [31:0]       r0, r1, r2, r3, r4, r5, r6;
        logic [31:0]       rdata;
        logic              ramp_on, halted, ramp_done;
        logic [11:0]       tmr;
        logic [19:0]       step_cnt;
        logic [INT_W-1:0]  cur_int;
        logic [FRAC_W-1:0] cur_frac;
        logic [23:0]       fl_cnt;
        logic              wide;
        logic [RB_W-1:0]   hold, shift;
        logic              rb_valid;
        logic [FRAC_W-1:0] a1, a2, a3;
        logic              c2d, c3d, c3dd;
        logic [INT_W-1:0]  sdm_int;
        logic [3:0]        sdm_off;
        logic              mux_out;
    } rtfl_state_t;

    rtfl_state_t s_r;
    rtfl_state_t s_nxt;
    logic        rst_s1_r;
    logic        rst_n_r;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops; assertion stays asynchronous.

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    logic              wr_en;
    logic              trig_rise;
    logic              sclk_rise;
    logic              step;
    logic              tmr_hit;
    logic [11:0]       rdiv;
    logic [19:0]       steps;
    logic [1:0]        irq_mode;
    logic [RB_W-1:0]   pos;
    logic [RB_W-1:0]   base;
    logic [FRAC_W:0]   sum1, sum2, sum3;
    logic [3:0]        off;

    // APB answers in the first access cycle; read data is taken at setup.
    assign pready  = psel & penable;
    assign wr_en   = psel & penable & pwrite;
    assign prdata  = s_r.rdata;

    always_comb begin
        s_nxt     = s_r;
        pslverr   = 1'b0;
        // The second and third flops of each synchroniser feed the edge detectors.
        s_nxt.trig_s1 = i_step_trigger_pin;
        s_nxt.trig_s2 = s_r.trig_s1;
        s_nxt.trig_d  = s_r.trig_s2;
        s_nxt.sclk_s1 = i_readback_clock_pin;
        s_nxt.sclk_s2 = s_r.sclk_s1;
        s_nxt.sclk_d  = s_r.sclk_s2;
        trig_rise = s_r.trig_s2 & ~s_r.trig_d;
        sclk_rise = s_r.sclk_s2 & ~s_r.sclk_d;
        irq_mode  = s_r.r5[IRQ_HI:IRQ_LO];
        rdiv      = s_r.r2[RDIV_HI:RDIV_LO];
        steps     = s_r.r6[STEPS_HI:STEPS_LO];
        base      = {s_r.r0[INT_HI:INT_LO], s_r.r0[FRM_HI:FRM_LO],
                     s_r.r1[FRL_HI:FRL_LO]};
        pos       = {s_r.cur_int, s_r.cur_frac};

        // Register file: unmapped addresses answer with an error.
        case (paddr)
            ADDR_R0, ADDR_R1, ADDR_R2, ADDR_R3, ADDR_R4, ADDR_R5, ADDR_R6,
            ADDR_STAT, ADDR_HINT, ADDR_HFRAC: pslverr = 1'b0;
            default: pslverr = pready;
        endcase
        if (psel && !penable) begin
            case (paddr)
                ADDR_R0:    s_nxt.rdata = s_r.r0;
                ADDR_R1:    s_nxt.rdata = s_r.r1;
                ADDR_R2:    s_nxt.rdata = s_r.r2;
                ADDR_R3:    s_nxt.rdata = s_r.r3;
                ADDR_R4:    s_nxt.rdata = s_r.r4;
                ADDR_R5:    s_nxt.rdata = s_r.r5;
                ADDR_R6:    s_nxt.rdata = s_r.r6;
                ADDR_STAT:  s_nxt.rdata = {28'h0000000, s_r.wide, s_r.halted,
                                           s_r.ramp_on, s_r.rb_valid};
                ADDR_HINT:  s_nxt.rdata = {20'h00000, s_r.hold[RB_W-1:FRAC_W]};
                ADDR_HFRAC: s_nxt.rdata = {7'h00, s_r.hold[FRAC_W-1:0]};
                default:    s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                ADDR_R1: s_nxt.r1 = pwdata;
                ADDR_R2: s_nxt.r2 = pwdata;
                ADDR_R3: s_nxt.r3 = pwdata;
                ADDR_R4: s_nxt.r4 = pwdata;
                ADDR_R5: s_nxt.r5 = pwdata;
                ADDR_R6: s_nxt.r6 = pwdata;
                default: s_nxt.r1 = s_nxt.r1;
            endcase
        end

        // Ramp timer; a zero divider is treated as one.
        tmr_hit = ({8'h00, s_r.tmr} + 20'h00001) >= {8'h00, rdiv};
        if (!s_r.ramp_on || s_r.halted || tmr_hit)
            s_nxt.tmr = 12'h000;
        else
            s_nxt.tmr = s_r.tmr + 12'h001;

        // External mode steps on trigger edges; a halting interrupt wins.
        if (s_r.r5[EXT_STEP])
            step = trig_rise && irq_mode != IRQ_STOP;
        else
            step = tmr_hit;
        step = step & s_r.ramp_on & ~s_r.halted;

        // Stepping adds the signed deviation word to the divide value.
        s_nxt.ramp_done = 1'b0;
        if (step) begin
            pos = pos + {{(RB_W-16){s_r.r5[DEV_HI]}}, s_r.r5[DEV_HI:DEV_LO]};
            if (s_r.step_cnt + 20'h00001 >= steps) begin
                s_nxt.ramp_done = 1'b1;
                s_nxt.step_cnt  = 20'h00000;
                pos             = base;
                // A single burst ends the ramp; other modes start over.
                if (s_r.r3[RMODE_HI:RMODE_LO] == RMODE_BURST)
                    s_nxt.ramp_on = 1'b0;
            end else begin
                s_nxt.step_cnt = s_r.step_cnt + 20'h00001;
            end
        end

        // Fast-lock countdown runs only outside ramp operation.
        if (s_r.fl_cnt != 24'h000000)
            s_nxt.fl_cnt = s_r.fl_cnt - 24'h000001;

        // Writing R0 reloads the divide value and may start a ramp.
        if (wr_en && paddr == ADDR_R0) begin
            s_nxt.r0       = pwdata;
            s_nxt.ramp_on  = pwdata[R0_START];
            s_nxt.halted   = 1'b0;
            s_nxt.step_cnt = 20'h00000;
            pos = {pwdata[INT_HI:INT_LO], pwdata[FRM_HI:FRM_LO],
                   s_r.r1[FRL_HI:FRL_LO]};
            if (s_r.r4[FL_HI:FL_LO] != FL_OFF)
                s_nxt.fl_cnt = 24'(rdiv) * 24'(s_r.r4[SDIV_HI:SDIV_LO]);
        end
        if (s_nxt.ramp_on)
            s_nxt.fl_cnt = 24'h000000;
        s_nxt.wide     = s_nxt.fl_cnt != 24'h000000;
        s_nxt.cur_int  = pos[RB_W-1:FRAC_W];
        s_nxt.cur_frac = pos[FRAC_W-1:0];

        // Readback shifter moves one bit per rising readback clock edge.
        if (sclk_rise)
            s_nxt.shift = {s_r.shift[RB_W-2:0], 1'b0};
        // An R4 write rearms readback; an interrupt in that cycle still wins.
        if (wr_en && paddr == ADDR_R4)
            s_nxt.rb_valid = 1'b0;
        if (trig_rise && irq_mode != IRQ_OFF) begin
            s_nxt.hold     = {s_r.cur_int, s_r.cur_frac};
            s_nxt.shift    = {s_r.cur_int, s_r.cur_frac};
            s_nxt.rb_valid = 1'b1;
            if (irq_mode == IRQ_STOP)
                s_nxt.halted = 1'b1;
        end

        // MASH 1-1-1 modulator on the current fraction, every clock.
        sum1 = {1'b0, s_r.a1} + {1'b0, s_r.cur_frac};
        sum2 = {1'b0, s_r.a2} + {1'b0, sum1[FRAC_W-1:0]};
        sum3 = {1'b0, s_r.a3} + {1'b0, sum2[FRAC_W-1:0]};
        s_nxt.a1   = sum1[FRAC_W-1:0];
        s_nxt.a2   = sum2[FRAC_W-1:0];
        s_nxt.a3   = sum3[FRAC_W-1:0];
        s_nxt.c2d  = sum2[FRAC_W];
        s_nxt.c3d  = sum3[FRAC_W];
        s_nxt.c3dd = s_r.c3d;
        off = {3'b000, sum1[FRAC_W]} + {3'b000, sum2[FRAC_W]}
            - {3'b000, s_r.c2d} + {3'b000, sum3[FRAC_W]}
            - {2'b00, s_r.c3d, 1'b0} + {3'b000, s_r.c3dd};
        s_nxt.sdm_off = off;
        s_nxt.sdm_int = s_r.cur_int;

        // Output pin selection.
        s_nxt.mux_out = 1'b0;
        if (s_r.r0[MUX_HI:MUX_LO] == MUX_SEL_RAMP) begin
            if (s_r.r4[TEST_HI:TEST_LO] == TEST_RAMP_DONE)
                s_nxt.mux_out = s_nxt.ramp_done;
            else if (s_r.r4[RB_HI:RB_LO] == RB_ENABLE)
                s_nxt.mux_out = s_nxt.shift[RB_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_r    <= '0;
            s_r.r0 <= REG_RESET;
            s_r.r4 <= REG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: mux and divide outputs straight from flip-flops; boost and switches decoded from flip-flops.

    // Only the divider setting 01 drives the boost and loop-filter switches.
    assign o_pump_gain_x16 = s_r.wide && s_r.r4[FL_HI:FL_LO] == FL_DIVIDER;
    assign o_filter_switch_ground  = o_pump_gain_x16;
    assign o_filter_switch_pump    = o_pump_gain_x16;
    assign o_multiplexed_output_pin = s_r.mux_out;
    assign o_divide_int    = s_r.sdm_int;
    assign o_divide_offset = s_r.sdm_off;

endmodule // rtfl_core

// file: verification/rtfl_core_props.sv
// Port checker for the ramp, readback and fast-lock block.
// Assumes register writes land at the APB access edge; bound to every instance.
`timescale 1ns/100ps
module rtfl_core_props
    import rtfl_pkg::*;
(
    input wire logic        i_clock,                  // Clock.
    input wire logic        i_rstn,                   // Reset, active low.
    input wire logic        psel,                     // APB select.
    input wire logic        penable,                  // APB access.
    input wire logic        pwrite,                   // APB write.
    input wire logic [7:0]  paddr,                    // APB address.
    input wire logic [31:0] pwdata,                   // APB write data.
    input wire logic        pslverr,                  // APB error.
    input wire logic        i_step_trigger_pin,       // Trigger pin.
    input wire logic        o_multiplexed_output_pin, // Output pin.
    input wire logic        o_pump_gain_x16,          // Pump boost.
    input wire logic        o_filter_switch_ground,   // Ground switch.
    input wire logic        o_filter_switch_pump,     // Pump switch.
    input wire logic [3:0]  o_divide_offset           // Modulator offset.
);
    logic [31:0] r0_r, r2_r, r4_r, r5_r; // Shadows of the written words.
    logic [23:0] plen_r, wcnt_r;         // Expected and seen wide span.
    logic        wr, r0w, fl_go, rb_on, done_on;
    // Decoded conditions, kept outside the properties so they stay short.
    assign wr = psel && penable && pwrite;
    assign r0w = wr && paddr == ADDR_R0;
    assign fl_go = r0w && !pwdata[R0_START] && r4_r[FL_HI:FL_LO] == FL_DIVIDER
                   && r2_r[RDIV_HI:RDIV_LO] != 12'h0 && r4_r[SDIV_HI:SDIV_LO] != 12'h0;
    assign done_on = r0_r[MUX_HI:MUX_LO] == MUX_SEL_RAMP
                     && r4_r[TEST_HI:TEST_LO] == TEST_RAMP_DONE;
    assign rb_on = r0_r[MUX_HI:MUX_LO] == MUX_SEL_RAMP && r4_r[RB_HI:RB_LO] == RB_ENABLE
                   && r4_r[TEST_HI:TEST_LO] != TEST_RAMP_DONE && r5_r[IRQ_LO]
                   && r5_r[DEV_HI:DEV_LO] == 16'h0000;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadows follow writes, so the span is predicted without looking inside.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            r0_r   <= '0;
            r2_r   <= '0;
            r4_r   <= '0;
            r5_r   <= '0;
            plen_r <= '0;
            wcnt_r <= '0;
        end else begin
            if (r0w) r0_r <= pwdata;
            if (wr && paddr == ADDR_R2) r2_r <= pwdata;
            if (wr && paddr == ADDR_R4) r4_r <= pwdata;
            if (wr && paddr == ADDR_R5) r5_r <= pwdata;
            if (r0w) plen_r <= 24'(r2_r[RDIV_HI:RDIV_LO]) * 24'(r4_r[SDIV_HI:SDIV_LO]);
            wcnt_r <= r0w ? '0 : (o_pump_gain_x16 ? wcnt_r + 24'h1 : '0);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    property p_sw_tie; {o_filter_switch_ground, o_filter_switch_pump} == {2{o_pump_gain_x16}}; endproperty
    a_sw_tie: assert property (p_sw_tie) else $error("filter switches differ from boost");
    property p_wide_field; o_pump_gain_x16 |-> r4_r[FL_HI:FL_LO] == FL_DIVIDER; endproperty
    a_wide_field: assert property (p_wide_field) else $error("boost with wrong mode");
    property p_wide_start; fl_go |-> ##[1:2] o_pump_gain_x16; endproperty
    a_wide_start: assert property (p_wide_start) else $error("wide span did not start");
    property p_wide_len;
        $fell(o_pump_gain_x16) && !r0_r[R0_START] |-> wcnt_r == plen_r;
    endproperty
    a_wide_len: assert property (p_wide_len) else $error("wide span has wrong length");
    property p_ramp_off; r0w && pwdata[R0_START] |-> ##2 !o_pump_gain_x16 [*4]; endproperty
    a_ramp_off: assert property (p_ramp_off) else $error("boost while ramp runs");
    property p_off_range; !(o_divide_offset inside {[4'h5:4'hC]}); endproperty
    a_off_range: assert property (p_off_range) else $error("modulator offset out of range");
    property p_done_pulse;
        $rose(o_multiplexed_output_pin) && done_on |=> !o_multiplexed_output_pin;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("ramp done not one cycle");
    property p_rb_first;
        $rose(i_step_trigger_pin) && rb_on
            |-> ##5 (o_multiplexed_output_pin == r0_r[INT_HI]) [*2];
    endproperty
    a_rb_first: assert property (p_rb_first)
        else $error("first readback bit wrong");
    property p_slverr; pslverr |-> psel && penable; endproperty
    a_slverr: assert property (p_slverr) else $error("error outside access phase");
    c_wide: cover property ($fell(o_pump_gain_x16));
    c_done: cover property ($rose(o_multiplexed_output_pin) && done_on);
    c_rb: cover property ($rose(i_step_trigger_pin) && rb_on);
endmodule // rtfl_core_props
bind rtfl_core rtfl_core_props u_props (.i_clock, .i_rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .i_step_trigger_pin, .o_multiplexed_output_pin, .o_pump_gain_x16,
    .o_filter_switch_ground, .o_filter_switch_pump, .o_divide_offset);

// file: verification/rtfl_host_model.sv
// Host controller model driving the trigger pin and the readback clock.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module rtfl_host_model (
    input  wire logic i_clock,   // Phase-detector clock.
    input  wire logic i_mux_pin, // Device output pin.
    output logic      o_trigger, // Step trigger pin.
    output logic      o_rb_clock // Readback shift clock, idle low.
);
    initial o_trigger = 1'b0;
    initial o_rb_clock = 1'b0;
    // Each level stands four clocks, so edges stay well apart for the synchroniser.
    task automatic trig(input logic lvl);
        o_trigger <= lvl;
        repeat (4) @(posedge i_clock);
    endtask
    // Reads the word most significant bit first; the clock rests low outside a frame.
    task automatic read_word(output logic [36:0] w);
        for (int i = 36; i >= 0; i--) begin
            w[i] = i_mux_pin;
            o_rb_clock <= 1'b1;
            repeat (3) @(posedge i_clock);
            o_rb_clock <= 1'b0;
            repeat (4) @(posedge i_clock);
        end
    endtask
endmodule // rtfl_host_model

// file: verification/rtfl_core_tb.sv
// Self-checking bench for the ramp, readback and fast-lock block.
// Assumes the host model on the pins and the checker bound to the core.
`timescale 1ns/100ps
module rtfl_core_tb
    import rtfl_pkg::*;
;
    logic        i_clock, pready, pslverr, trig, rbclk, mux, pump, swg, swp, err, mux_q;
    logic        i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_en = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] dint;
    logic [3:0]  doff;
    logic [36:0] word;
    logic [1:0]  fl_tab [3] = '{FL_DIVIDER, 2'h2, FL_OFF};
    logic [1:0]  irq_tab [3] = '{IRQ_OFF, IRQ_CONTINUE, IRQ_STOP};
    int          error_cnt = 0, checks = 0, nwide = 0, ndone = 0, osum = 0, wbase = 0, dbase = 0;
    rtfl_core uut (.i_clock, .i_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .i_step_trigger_pin(trig), .i_readback_clock_pin(rbclk),
        .o_multiplexed_output_pin(mux), .o_pump_gain_x16(pump), .o_filter_switch_ground(swg),
        .o_filter_switch_pump(swp), .o_divide_int(dint), .o_divide_offset(doff));
    rtfl_host_model host (.i_clock, .i_mux_pin(mux), .o_trigger(trig), .o_rb_clock(rbclk));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    // Counts boost cycles with both switches closed, ramp-done pulses and the offset sum.
    always @(posedge i_clock) begin
        if (pump === 1'b1 && swg === 1'b1 && swp === 1'b1) nwide++;
        if (mux === 1'b1 && mux_q === 1'b0) ndone++;
        mux_q <= mux;
        if (acc_en) osum += int'($signed(doff));
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // A hang is cut short well past the expected run of about one thousand clocks.
    initial begin
        repeat (6000) @(posedge i_clock);
        error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clock);
        apb(1'b0, ADDR_R0, 32'h0);
        chk(37'(rd), 37'(REG_RESET));
        apb(1'b1, ADDR_R2, 32'h0000_0018);
        apb(1'b0, ADDR_R2, 32'h0);
        chk(37'(rd), 37'h18);
        apb(1'b0, 8'h30, 32'h0);
        chk(37'({err, rd}), 37'h1_0000_0000);
        $display("test registers done");
        // Only the divider mode gives a boost, lasting the product of the two dividers.
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_R4, (32'(fl_tab[i]) << FL_LO) | 32'h280);
            wbase = nwide;
            apb(1'b1, ADDR_R0, 32'h052E_0000);
            repeat (30) @(posedge i_clock);
            chk(37'(nwide - wbase), 37'(i == 0 ? 15 : 0));
        end
        chk(37'(dint), 37'hA5C);
        $display("test fast lock done");
        // Half fraction: offsets over 64 clocks must sum close to 32.
        apb(1'b1, ADDR_R1, 32'h0);
        apb(1'b1, ADDR_R0, 32'h052E_4000);
        repeat (8) @(posedge i_clock);
        acc_en <= 1'b1;
        repeat (64) @(posedge i_clock);
        acc_en <= 1'b0;
        chk(37'(osum >= 28 && osum <= 36), 37'h1);
        $display("test modulator done");
        // One burst of two steps: one done pulse and no wide span.
        apb(1'b1, ADDR_R6, 32'h10);
        apb(1'b1, ADDR_R3, 32'h0C00);
        apb(1'b1, ADDR_R4, 32'h0068_0280);
        wbase = nwide;
        dbase = ndone;
        apb(1'b1, ADDR_R0, 32'hFD2E_0000);
        repeat (100) @(posedge i_clock);
        chk(37'(nwide - wbase), 37'h0);
        chk(37'(ndone - dbase), 37'h1);
        $display("test ramp done");
        // External stepping: nothing moves until the trigger pin pulses.
        apb(1'b1, ADDR_R3, 32'h0);
        apb(1'b1, ADDR_R5, 32'h2000_0000);
        apb(1'b1, ADDR_R0, 32'hFD2E_0000);
        dbase = ndone;
        repeat (60) @(posedge i_clock);
        chk(37'(ndone - dbase), 37'h0);
        for (int i = 0; i < 8; i++) host.trig(i[0] ? 1'b0 : 1'b1);
        chk(37'(ndone != dbase), 37'h1);
        $display("test external step done");
        // Each interrupt mode, with status read while the trigger is still high.
        apb(1'b1, ADDR_R1, 32'h0D5E_0000);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_R5, 32'(irq_tab[i]) << IRQ_LO);
            apb(1'b1, ADDR_R4, 32'h0040_0000);
            apb(1'b1, ADDR_R0, 32'hFD2E_2D18);
            host.trig(1'b1);
            apb(1'b0, ADDR_STAT, 32'h0);
            chk(37'(rd & 32'h5), 37'(i == 0 ? 0 : (i == 1 ? 1 : 5)));
            host.trig(1'b0);
            if (i != 0) begin
                apb(1'b0, ADDR_HFRAC, 32'h0);
                chk(37'(rd), 37'h0B4_7ABC);
                host.read_word(word);
                chk(word, {12'hA5C, 25'h0B4_7ABC});
            end
        end
        $display("test interrupt readback done");
        finish_test();
    end
endmodule // rtfl_core_tb
